// File: design/pmp_defs.vh
// Purpose: shared constants of the program memory partition block
// Assumes: included by bare name from every design file
// Notes:   definitions only
`ifndef PMP_DEFS_VH
`define PMP_DEFS_VH

`define PMP_PC_W        15
`define PMP_WORD_W      14
`define PMP_MEM_AW      13
`define PMP_MEM_DEPTH   8192
`define PMP_RST_VEC     15'h0000
`define PMP_INT_VEC     15'h0004
`define PMP_MASK_SMALL  15'h0fff
`define PMP_MASK_BIG    15'h1fff
`define PMP_HALF_SMALL  15'h07ff
`define PMP_HALF_BIG    15'h0fff
`define PMP_SAF_SPAN    15'h007f
`define PMP_BOOT_END7   15'h01ff
`define PMP_BOOT_END6   15'h03ff
`define PMP_BOOT_END5   15'h07ff
`define PMP_BOOT_END4   15'h0fff
`define PMP_BOOT_ENDX   15'h3fff
`define PMP_BSZ_7       3'h7
`define PMP_BSZ_6       3'h6
`define PMP_BSZ_5       3'h5
`define PMP_BSZ_4       3'h4
`define PMP_PROG_BIT    7
`define PMP_NV_SPACE    15
`define PMP_EE_BASE     16'hf000
`define PMP_EE_LAST     16'hf0ff
`define PMP_CFG_ADDR    16'h8009

`define PMP_AXI_AW      8
`define PMP_REG_CFG     8'h00
`define PMP_REG_NVC     8'h04
`define PMP_REG_PWR     8'h08
`define PMP_REG_STAT    8'h0c
`define PMP_RESP_OKAY   2'h0
`define PMP_RESP_SLVERR 2'h2

`define PMP_CFG_RST     16'h8f9f
`define PMP_CFG_WMASK   16'h8f9f
`define PMP_F_BSZ_HI    2
`define PMP_F_BOOT_BLOCK_ENABLE_N      3
`define PMP_F_STORAGE_FLASH_ENABLE_N     4
`define PMP_F_WAPP      7
`define PMP_F_WBOOT     8
`define PMP_F_WCFG      9
`define PMP_F_WEE       10
`define PMP_F_WSAF      11
`define PMP_F_BIG       15
`define PMP_F_WRITE_ERROR_FLAG     3
`define PMP_F_XSTAT     1

`endif

// File: design/pmp_flash_mem.v
// Purpose: program word array, one fetch read port, one data read/write port
// Assumes: single clock, registered read data on both ports
// Notes:   holds no reset; contents are whatever was written
`timescale 1ns/1ns
`include "pmp_defs.vh"
module pmp_flash_mem (
  input  wire                     clk,
  input  wire [`PMP_MEM_AW-1:0]   a_addr,
  input  wire                     a_en,
  output reg  [`PMP_WORD_W-1:0]   a_rdata_q,
  input  wire [`PMP_MEM_AW-1:0]   b_addr,
  input  wire                     b_en,
  input  wire                     b_we,
  input  wire [`PMP_WORD_W-1:0]   b_wdata,
  output reg  [`PMP_WORD_W-1:0]   b_rdata_q
);
  reg [`PMP_WORD_W-1:0] mem [0:`PMP_MEM_DEPTH-1];

  // separate ports let a fetch and a data access share a cycle
  always @(posedge clk)
  begin
    if (a_en)
      a_rdata_q <= mem[a_addr];
  end

  always @(posedge clk)
  begin
    if (b_en)
    begin
      if (b_we)
        mem[b_addr] <= b_wdata;
      b_rdata_q <= mem[b_addr];
    end
  end
endmodule // pmp_flash_mem

// File: design/pmp_region_dec.v
// Purpose: classify a masked program address into boot, app or storage block
// Assumes: address already wrapped into the implemented size
// Notes:   purely combinational
`timescale 1ns/1ns
`include "pmp_defs.vh"
module pmp_region_dec (
  input  wire [`PMP_PC_W-1:0] addr,
  input  wire                 big,
  input  wire                 boot_block_enable_n,
  input  wire [2:0]           boot_size_select,
  input  wire                 storage_flash_enable_n,
  output reg                  in_boot,
  output reg                  in_app,
  output reg                  in_saf
);
  reg [`PMP_PC_W-1:0] last;
  reg [`PMP_PC_W-1:0] half;
  reg [`PMP_PC_W-1:0] bend;

  always @*
  begin
    last = big ? `PMP_MASK_BIG : `PMP_MASK_SMALL;
    half = big ? `PMP_HALF_BIG : `PMP_HALF_SMALL;
    case (boot_size_select)
      `PMP_BSZ_7: bend = `PMP_BOOT_END7;
      `PMP_BSZ_6: bend = `PMP_BOOT_END6;
      `PMP_BSZ_5: bend = `PMP_BOOT_END5;
      `PMP_BSZ_4: bend = `PMP_BOOT_END4;
      default:    bend = `PMP_BOOT_ENDX;
    endcase
    if (bend > half)
      bend = half;
    in_saf  = ~storage_flash_enable_n && (addr >= (last - `PMP_SAF_SPAN));
    in_boot = ~boot_block_enable_n && (addr <= bend);
    in_app  = ~in_saf & ~in_boot;
  end
endmodule // pmp_region_dec

// File: design/pmp_top.v
// Purpose: program memory partition checker with AXI4-Lite control registers
// Assumes: core strobes are one-cycle pulses synchronous to CLK
// Notes:   fetch and data paths use separate memory ports
// Functional notes
// - fifteen-bit program counter, 32K by 14 space
// - accesses above implemented size wrap silently
// - 4096 or 8192 implemented words
// - reset vector 0000h, interrupt vector 0004h
// - pointer bit 7 reads program low byte
// - indirect writes never change program memory
// - indirect program read costs one extra cycle
// - independent fetch and data buses
// - both enables inactive: all application block
// - boot block from 0000h to size end
// - storage block is top 128 words
// - storage block never valid for execution
// - storage block uses common nonvolatile path
// - each region has own write protect
// - protected write refused, sets write error
// - bad fetch resets, clears violation status
// - EEPROM reached at F000h-F0FFh via registers
// - boot enable bit is active low
// - size field ends; clamp at half memory
// - write protect bits are active low
`timescale 1ns/1ns
`include "pmp_defs.vh"
module pmp_top (
  input  wire                      CLK,
  input  wire                      RSTN,
  input  wire [`PMP_AXI_AW-1:0]    AWADDR,
  input  wire                      AWVALID,
  output reg                       AWREADY,
  input  wire [31:0]               WDATA,
  input  wire [3:0]                WSTRB,
  input  wire                      WVALID,
  output reg                       WREADY,
  output reg  [1:0]                BRESP,
  output reg                       BVALID,
  input  wire                      BREADY,
  input  wire [`PMP_AXI_AW-1:0]    ARADDR,
  input  wire                      ARVALID,
  output reg                       ARREADY,
  output reg  [31:0]               RDATA,
  output reg  [1:0]                RRESP,
  output reg                       RVALID,
  input  wire                      RREADY,
  input  wire                      PC_LOAD,
  input  wire [`PMP_PC_W-1:0]      PC_TARGET,
  input  wire                      PC_STEP,
  input  wire                      INT_ENTRY,
  input  wire                      FETCH_EN,
  output reg  [`PMP_PC_W-1:0]      FETCH_ADDR,
  output wire [`PMP_WORD_W-1:0]    FETCH_WORD,
  output reg                       FETCH_VALID,
  output reg                       EXEC_VIOL_RST,
  input  wire                      IND_RD,
  input  wire [7:0]                POINTER_HIGH_BYTE,
  input  wire [7:0]                POINTER_LOW_BYTE,
  output reg  [7:0]                IND_RDATA,
  output reg                       IND_VALID,
  output reg                       IND_BUSY,
  input  wire                      NV_RD,
  input  wire                      NV_WR,
  input  wire [15:0]               NV_ADDR,
  input  wire [`PMP_WORD_W-1:0]    NV_WDATA,
  output reg  [`PMP_WORD_W-1:0]    NV_RDATA,
  output reg                       NV_VALID,
  output reg                       EE_WR,
  output reg  [7:0]                EE_ADDR,
  output reg  [7:0]                EE_WDATA,
  output reg                       WRITE_ERROR
);
  reg  [`PMP_PC_W-1:0]   pc_q;
  reg  [15:0]            cfg_q;
  reg                    exec_violation_status_q;
  reg  [`PMP_AXI_AW-1:0] awaddr_q;
  reg  [31:0]            wdata_q;
  reg  [3:0]             wstrb_q;
  reg                    fetch_saf_q;
  reg                    ind_p1_q;
  reg                    nv_p1_q;
  reg                    nv_cfg_rd_q;
  wire [`PMP_WORD_W-1:0] b_rdata;
  wire                   big;
  wire                   f_saf;
  wire                   w_boot;
  wire                   w_app;
  wire                   w_saf;
  wire [`PMP_PC_W-1:0]   fetch_a;
  wire [`PMP_PC_W-1:0]   ind_a;
  wire [`PMP_PC_W-1:0]   nv_a;
  wire                   ind_go;
  wire                   nv_pfm;
  wire                   nv_cfg;
  wire                   nv_ee;
  wire                   pfm_prot;
  wire                   wr_refused;
  wire                   nv_pfm_ok;
  wire                   do_wr;
  wire [31:0]            cfg_rd;
  wire [31:0]            cfg_merged;
  reg  [31:0]            rd_mux;
  reg                    rd_hit;

  assign big = cfg_q[`PMP_F_BIG];
  // only the low half holds register bits; upper lanes are dropped on purpose
  assign cfg_merged = lane_merge({16'h0000, cfg_q}, wdata_q, wstrb_q);

  // wrap-around by masking, never a fault
  function [`PMP_PC_W-1:0] wrap_addr;
    input [`PMP_PC_W-1:0] a;
    input                 b;
    begin
      wrap_addr = a & (b ? `PMP_MASK_BIG : `PMP_MASK_SMALL);
    end
  endfunction

  // byte-lane merge for AXI writes
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          lane_merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // size field frozen once the boot block is enabled
  function [15:0] cfg_update;
    input [15:0] old;
    input [15:0] nw;
    begin
      cfg_update = (nw & `PMP_CFG_WMASK) | (old & ~`PMP_CFG_WMASK);
      if (~old[`PMP_F_BOOT_BLOCK_ENABLE_N])
        cfg_update[`PMP_F_BSZ_HI:0] = old[`PMP_F_BSZ_HI:0];
    end
  endfunction

  assign fetch_a = wrap_addr(pc_q, big);
  assign ind_a   = wrap_addr({POINTER_HIGH_BYTE[6:0], POINTER_LOW_BYTE}, big);
  assign nv_a    = wrap_addr(NV_ADDR[`PMP_PC_W-1:0], big);
  assign ind_go  = IND_RD & POINTER_HIGH_BYTE[`PMP_PROG_BIT];

  pmp_region_dec u_fetch_dec (
    .addr                   (fetch_a),
    .big                    (big),
    .boot_block_enable_n    (cfg_q[`PMP_F_BOOT_BLOCK_ENABLE_N]),
    .boot_size_select       (cfg_q[`PMP_F_BSZ_HI:0]),
    .storage_flash_enable_n (cfg_q[`PMP_F_STORAGE_FLASH_ENABLE_N]),
    .in_boot                (),
    .in_app                 (),
    .in_saf                 (f_saf)
  );

  pmp_region_dec u_write_dec (
    .addr                   (nv_a),
    .big                    (big),
    .boot_block_enable_n    (cfg_q[`PMP_F_BOOT_BLOCK_ENABLE_N]),
    .boot_size_select       (cfg_q[`PMP_F_BSZ_HI:0]),
    .storage_flash_enable_n (cfg_q[`PMP_F_STORAGE_FLASH_ENABLE_N]),
    .in_boot                (w_boot),
    .in_app                 (w_app),
    .in_saf                 (w_saf)
  );

  // nonvolatile address spaces: program, config word, EEPROM
  assign nv_pfm = ~NV_ADDR[`PMP_NV_SPACE];
  assign nv_cfg = (NV_ADDR == `PMP_CFG_ADDR);
  assign nv_ee  = (NV_ADDR >= `PMP_EE_BASE) && (NV_ADDR <= `PMP_EE_LAST);

  assign pfm_prot = (w_app  & ~cfg_q[`PMP_F_WAPP])
                  | (w_boot & ~cfg_q[`PMP_F_WBOOT])
                  | (w_saf  & ~cfg_q[`PMP_F_WSAF]);
  assign wr_refused = NV_WR & ((nv_pfm & pfm_prot)
                  | (nv_cfg & ~cfg_q[`PMP_F_WCFG])
                  | (nv_ee  & ~cfg_q[`PMP_F_WEE]));
  // indirect reads own the data port; indirect writes have no path here
  assign nv_pfm_ok = NV_WR & nv_pfm & ~pfm_prot & ~ind_go;

  pmp_flash_mem u_mem (
    .clk       (CLK),
    .a_addr    (fetch_a[`PMP_MEM_AW-1:0]),
    .a_en      (FETCH_EN),
    .a_rdata_q (FETCH_WORD),
    .b_addr    (ind_go ? ind_a[`PMP_MEM_AW-1:0] : nv_a[`PMP_MEM_AW-1:0]),
    .b_en      (ind_go | nv_pfm_ok | (NV_RD & nv_pfm)),
    .b_we      (nv_pfm_ok),
    .b_wdata   (NV_WDATA),
    .b_rdata_q (b_rdata)
  );

  // program counter, reset vector and interrupt entry
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      pc_q <= `PMP_RST_VEC;
    else if (INT_ENTRY)
      pc_q <= `PMP_INT_VEC;
    else if (PC_LOAD)
      pc_q <= PC_TARGET;
    else if (PC_STEP)
      pc_q <= wrap_addr(pc_q + 15'h0001, big);
  end

  // fetch pipeline and execution check
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      FETCH_ADDR    <= `PMP_RST_VEC;
      FETCH_VALID   <= 1'b0;
      fetch_saf_q   <= 1'b0;
      EXEC_VIOL_RST <= 1'b0;
    end
    else
    begin
      FETCH_ADDR    <= fetch_a;
      FETCH_VALID   <= FETCH_EN;
      fetch_saf_q   <= FETCH_EN & f_saf;
      // executing the fetched word from storage triggers the reset pulse
      EXEC_VIOL_RST <= FETCH_VALID & fetch_saf_q;
    end
  end

  // indirect and nonvolatile data reads
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ind_p1_q    <= 1'b0;
      IND_BUSY    <= 1'b0;
      IND_VALID   <= 1'b0;
      IND_RDATA   <= 8'h00;
      nv_p1_q     <= 1'b0;
      nv_cfg_rd_q <= 1'b0;
      NV_VALID    <= 1'b0;
      NV_RDATA    <= {`PMP_WORD_W{1'b0}};
    end
    else
    begin
      ind_p1_q  <= ind_go;
      // stall for the extra cycle the memory read costs
      IND_BUSY  <= ind_go;
      IND_VALID <= ind_p1_q;
      if (ind_p1_q)
        IND_RDATA <= b_rdata[7:0];
      nv_p1_q     <= NV_RD & ~ind_go;
      nv_cfg_rd_q <= NV_RD & nv_cfg;
      NV_VALID    <= nv_p1_q;
      if (nv_p1_q)
        NV_RDATA <= nv_cfg_rd_q ? cfg_q[`PMP_WORD_W-1:0] : b_rdata;
    end
  end

  // EEPROM writes go out to its own control registers
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      EE_WR    <= 1'b0;
      EE_ADDR  <= 8'h00;
      EE_WDATA <= 8'h00;
    end
    else
    begin
      EE_WR <= NV_WR & nv_ee & cfg_q[`PMP_F_WEE];
      if (NV_WR & nv_ee)
      begin
        EE_ADDR  <= NV_ADDR[7:0];
        EE_WDATA <= NV_WDATA[7:0];
      end
    end
  end

  // AXI4-Lite write channel: address and data taken in either order
  assign do_wr = ~AWREADY & ~WREADY & ~BVALID;

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      AWREADY  <= 1'b1;
      WREADY   <= 1'b1;
      BVALID   <= 1'b0;
      BRESP    <= `PMP_RESP_OKAY;
      awaddr_q <= {`PMP_AXI_AW{1'b0}};
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end
    else
    begin
      if (AWVALID & AWREADY)
      begin
        awaddr_q <= AWADDR;
        AWREADY  <= 1'b0;
      end
      if (WVALID & WREADY)
      begin
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
        WREADY  <= 1'b0;
      end
      if (do_wr)
      begin
        BVALID <= 1'b1;
        case (awaddr_q)
          `PMP_REG_CFG, `PMP_REG_NVC, `PMP_REG_PWR, `PMP_REG_STAT:
            BRESP <= `PMP_RESP_OKAY;
          default:
            BRESP <= `PMP_RESP_SLVERR;
        endcase
      end
      if (BVALID & BREADY)
      begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  // configuration and status bits; hardware events beat software writes
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cfg_q                   <= `PMP_CFG_RST;
      WRITE_ERROR             <= 1'b0;
      exec_violation_status_q <= 1'b1;
    end
    else
    begin
      if (do_wr && awaddr_q == `PMP_REG_CFG)
        cfg_q <= cfg_update(cfg_q, cfg_merged[15:0]);
      else if (NV_WR & nv_cfg & cfg_q[`PMP_F_WCFG] & ~ind_go)
        cfg_q <= cfg_update(cfg_q, {2'b00, NV_WDATA});
      if (wr_refused)
        WRITE_ERROR <= 1'b1;
      else if (do_wr && awaddr_q == `PMP_REG_NVC && wstrb_q[0]
               && ~wdata_q[`PMP_F_WRITE_ERROR_FLAG])
        WRITE_ERROR <= 1'b0;
      if (EXEC_VIOL_RST)
        exec_violation_status_q <= 1'b0;
      else if (do_wr && awaddr_q == `PMP_REG_PWR && wstrb_q[0]
               && wdata_q[`PMP_F_XSTAT])
        exec_violation_status_q <= 1'b1;
    end
  end

  // AXI4-Lite read channel, one-cycle answer
  assign cfg_rd = {16'h0000, cfg_q};

  always @*
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (ARADDR)
      `PMP_REG_CFG:  rd_mux = cfg_rd;
      `PMP_REG_NVC:  rd_mux[`PMP_F_WRITE_ERROR_FLAG] = WRITE_ERROR;
      `PMP_REG_PWR:  rd_mux[`PMP_F_XSTAT] = exec_violation_status_q;
      `PMP_REG_STAT: rd_mux[`PMP_PC_W-1:0] = pc_q;
      default:       rd_hit = 1'b0;
    endcase
  end

  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= `PMP_RESP_OKAY;
    end
    else
    begin
      if (ARVALID & ARREADY)
      begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RDATA   <= rd_mux;
        RRESP   <= rd_hit ? `PMP_RESP_OKAY : `PMP_RESP_SLVERR;
      end
      else if (RVALID & RREADY)
      begin
        RVALID  <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end
endmodule // pmp_top

// File: dv/pmp_top_properties.sv
// Purpose: port-level checks on pmp_top
// Assumes: one clock, RSTN async active low, 8K variant
// Notes: bound from the bench top file
`timescale 1ns/1ns
`include "pmp_defs.vh"
module pmp_props (
  input wire                 CLK,
  input wire                 RSTN,
  input wire                 FETCH_EN,
  input wire                 FETCH_VALID,
  input wire [`PMP_PC_W-1:0] FETCH_ADDR,
  input wire                 INT_ENTRY,
  input wire                 EXEC_VIOL_RST,
  input wire                 IND_RD,
  input wire [7:0]           POINTER_HIGH_BYTE,
  input wire                 IND_BUSY,
  input wire                 IND_VALID,
  input wire                 NV_RD,
  input wire                 NV_WR,
  input wire [15:0]          NV_ADDR,
  input wire                 NV_VALID,
  input wire                 EE_WR,
  input wire                 WRITE_ERROR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire ind_go = IND_RD && POINTER_HIGH_BYTE[7];
  wire nv_ee  = NV_WR && (NV_ADDR[15:8] == 8'hf0);

  a_fetch_lat: assert property (FETCH_VALID == $past(FETCH_EN))
    else $error("fetch valid not one cycle after enable");
  a_fetch_wrap: assert property (FETCH_VALID |-> FETCH_ADDR[14:13] == 2'b00)
    else $error("fetch address not wrapped");
  a_int_vector: assert property ($past(INT_ENTRY) && FETCH_EN |=> FETCH_ADDR == 15'h0004)
    else $error("interrupt fetch not at vector");
  a_ind_stall: assert property (ind_go |=> IND_BUSY ##1 IND_VALID)
    else $error("indirect read missing stall cycle");
  a_ind_gate: assert property (!ind_go |=> !IND_BUSY)
    else $error("indirect read without pointer bit");
  a_viol_src: assert property (EXEC_VIOL_RST |-> $past(FETCH_VALID) && FETCH_ADDR[12:7] == 6'h3f)
    else $error("violation not from storage fetch");
  a_werr_cause: assert property ($rose(WRITE_ERROR) |-> $past(NV_WR))
    else $error("write error without nv write");
  a_ee_cause: assert property (EE_WR |-> $past(nv_ee))
    else $error("eeprom write without eeprom address");
  a_nv_lat: assert property (NV_RD && !ind_go |-> ##2 NV_VALID)
    else $error("nv read answer late");

  cover property (EXEC_VIOL_RST);
  cover property (EE_WR);
  cover property ($rose(WRITE_ERROR));
  cover property (ind_go ##2 IND_VALID);
endmodule // pmp_props

// File: dv/pmp_core_model.sv
// Purpose: core side model, fetch and data paths
// Assumes: called at a rising clk edge
// Notes: released address lines show inverted value, not stale
`timescale 1ns/1ns
module pmp_core_model (
  input  wire        clk,
  input  wire        nv_valid,
  input  wire [13:0] nv_rdata,
  output reg         pc_load,
  output reg  [14:0] pc_target,
  output reg         pc_step,
  output reg         int_entry,
  output reg         fetch_en,
  output reg         ind_rd,
  output reg  [7:0]  ptr_hi,
  output reg  [7:0]  ptr_lo,
  output reg         nv_rd,
  output reg         nv_wr,
  output reg  [15:0] nv_addr,
  output reg  [13:0] nv_wdata
);
  initial
  begin
    {pc_load, pc_step, int_entry, fetch_en, ind_rd, nv_rd, nv_wr} = 7'h00;
    {pc_target, ptr_hi, ptr_lo, nv_addr, nv_wdata} = '0;
  end
  task automatic fetch(input [14:0] p, input bit vec);
    if (vec) int_entry <= 1'b1;
    else pc_load <= 1'b1;
    pc_target <= p;
    @(posedge clk);
    {int_entry, pc_load} <= 2'b00;
    pc_target <= ~p;
    fetch_en <= 1'b1;
    @(posedge clk);
    fetch_en <= 1'b0;
  endtask
  task automatic ind(input [7:0] h, input [7:0] l);
    ind_rd <= 1'b1;
    {ptr_hi, ptr_lo} <= {h, l};
    @(posedge clk);
    ind_rd <= 1'b0;
    {ptr_hi, ptr_lo} <= ~{h, l};
  endtask
  task automatic wr(input [15:0] a, input [13:0] d);
    nv_wr <= 1'b1;
    {nv_addr, nv_wdata} <= {a, d};
    @(posedge clk);
    nv_wr <= 1'b0;
    {nv_addr, nv_wdata} <= ~{a, d};
    @(posedge clk);
  endtask
  task automatic rd(input [15:0] a, output [13:0] d);
    d = 'x;
    nv_rd <= 1'b1;
    nv_addr <= a;
    @(posedge clk);
    nv_rd <= 1'b0;
    nv_addr <= ~a;
    repeat (6)
    begin
      @(posedge clk);
      if (nv_valid)
      begin
        d = nv_rdata;
        break;
      end
    end
  endtask
endmodule // pmp_core_model

// File: dv/program_memory_partition_tb.sv
// Purpose: self-checking bench of pmp_top
// Assumes: 8K variant, core model drives fetch and nv traffic
// Notes: AXI4-Lite master tasks, samples taken at clock edges
`timescale 1ns/1ns
`include "pmp_defs.vh"
module program_memory_partition_tb;
  logic        CLK, RSTN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, PC_LOAD, PC_STEP, INT_ENTRY;
  logic        FETCH_EN, FETCH_VALID, EXEC_VIOL_RST, IND_RD, IND_VALID, IND_BUSY;
  logic        NV_RD, NV_WR, NV_VALID, EE_WR, WRITE_ERROR;
  logic [7:0]  AWADDR, ARADDR, POINTER_HIGH_BYTE, POINTER_LOW_BYTE, IND_RDATA, EE_ADDR, EE_WDATA;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic [14:0] PC_TARGET, FETCH_ADDR;
  logic [13:0] FETCH_WORD, NV_WDATA, NV_RDATA;
  logic [15:0] NV_ADDR;
  int          miscompares, n_compared;

  pmp_top uut (.CLK, .RSTN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .PC_LOAD, .PC_TARGET, .PC_STEP, .INT_ENTRY, .FETCH_EN, .FETCH_ADDR, .FETCH_WORD,
    .FETCH_VALID, .EXEC_VIOL_RST, .IND_RD, .POINTER_HIGH_BYTE, .POINTER_LOW_BYTE, .IND_RDATA,
    .IND_VALID, .IND_BUSY, .NV_RD, .NV_WR, .NV_ADDR, .NV_WDATA, .NV_RDATA, .NV_VALID, .EE_WR,
    .EE_ADDR, .EE_WDATA, .WRITE_ERROR);
  pmp_core_model core (.clk(CLK), .nv_valid(NV_VALID), .nv_rdata(NV_RDATA), .pc_load(PC_LOAD),
    .pc_target(PC_TARGET), .pc_step(PC_STEP), .int_entry(INT_ENTRY), .fetch_en(FETCH_EN),
    .ind_rd(IND_RD), .ptr_hi(POINTER_HIGH_BYTE), .ptr_lo(POINTER_LOW_BYTE), .nv_rd(NV_RD),
    .nv_wr(NV_WR), .nv_addr(NV_ADDR), .nv_wdata(NV_WDATA));

  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // a wait that used its whole bound ends the run
  task automatic hang(input int n);
    if (n >= 40)
    begin
      miscompares++;
      end_of_test;
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    {AWADDR, WDATA} <= {a, d};
    {AWVALID, WVALID, BREADY} <= 3'b111;
    for (n = 0; n < 40; n++)
    begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    hang(n);
    chk("bresp", er, BRESP);
    BREADY <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    ARADDR <= a;
    {ARVALID, RREADY} <= 2'b11;
    for (n = 0; n < 40; n++)
    begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    hang(n);
    {d, r} = {RDATA, RRESP};
    RREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(8'h00, d, r);
    chk("cfg reset", 32'h8f9f, d);
    axi_rd(8'h0c, d, r);
    chk("pc at reset", 32'h0, d);
    axi_rd(8'h10, d, r);
    chk("unmapped rresp", 2'h2, r);
    axi_wr(8'h14, 32'h0, 2'h2);
  endtask
  task automatic t_fetch;
    logic [13:0] w;
    core.wr(16'h0005, 14'h2a5c);
    core.rd(16'h0005, w);
    chk("nv readback", 14'h2a5c, w);
    core.fetch(15'h6005, 1'b0);
    @(posedge CLK);
    chk("wrapped addr", 15'h0005, FETCH_ADDR);
    chk("fetch word", 14'h2a5c, FETCH_WORD);
    core.fetch(15'h0123, 1'b1);
    @(posedge CLK);
    chk("vector addr", 15'h0004, FETCH_ADDR);
    core.ind(8'h80, 8'h05);
    @(posedge CLK);
    chk("ind stall", 1'b1, IND_BUSY);
    @(posedge CLK);
    chk("ind data", 8'h5c, IND_RDATA);
    chk("ind valid", 1'b1, IND_VALID);
    core.ind(8'h00, 8'h05);
    @(posedge CLK);
    chk("ind ignored", 1'b0, IND_BUSY);
    axi_wr(8'h00, 32'h0f9f, 2'h0);
    core.fetch(15'h1005, 1'b0);
    @(posedge CLK);
    chk("wrap small", 15'h0005, FETCH_ADDR);
  endtask
  task automatic t_saf;
    logic [31:0] d;
    logic [1:0]  r;
    core.fetch(15'h1fff, 1'b0);
    repeat (2) @(posedge CLK);
    chk("viol saf off", 1'b0, EXEC_VIOL_RST);
    axi_wr(8'h00, 32'h8f8f, 2'h0);
    core.fetch(15'h1f80, 1'b0);
    repeat (2) @(posedge CLK);
    chk("viol reset", 1'b1, EXEC_VIOL_RST);
    axi_rd(8'h08, d, r);
    chk("viol status", 1'b0, d[1]);
    core.fetch(15'h1f7f, 1'b0);
    repeat (2) @(posedge CLK);
    chk("viol app top", 1'b0, EXEC_VIOL_RST);
  endtask
  // one protection setting per row, error expected or not
  task automatic t_prot;
    logic [15:0] cf [8] = '{16'h8f9f, 16'h8f1f, 16'h8e97, 16'h8e97, 16'h878f, 16'h878f,
                            16'h8b9f, 16'h8d9f};
    logic [15:0] ad [8] = '{16'h0100, 16'h0100, 16'h01ff, 16'h0200, 16'h1f80, 16'h1f7f,
                            16'hf034, 16'h8009};
    logic [7:0]  er = 8'b1101_0110;
    logic [13:0] w;
    logic [31:0] d;
    logic [1:0]  r;
    core.wr(16'hf012, 14'h00a5);
    chk("ee addr", 8'h12, EE_ADDR);
    chk("ee data", 8'ha5, EE_WDATA);
    chk("ee strobe", 1'b1, EE_WR);
    for (int i = 0; i < 8; i++)
    begin
      axi_wr(8'h00, {16'h0, cf[i]}, 2'h0);
      axi_wr(8'h04, 32'h0, 2'h0);
      core.wr(ad[i], {11'h600, i[2:0]});
      chk("write error", er[i], WRITE_ERROR);
      if (i == 6)
        chk("ee kept", 1'b0, EE_WR);
    end
    axi_rd(8'h04, d, r);
    chk("error flag", 1'b1, d[3]);
    core.rd(16'h0100, w);
    chk("app kept", 14'h3000, w);
  endtask

  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  initial
  begin
    RSTN = 1'b0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, WDATA} = '0;
    WSTRB = 4'hf;
    miscompares = 0;
    n_compared = 0;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    t_regs;
    t_fetch;
    t_saf;
    t_prot;
    end_of_test;
  end
endmodule // program_memory_partition_tb

bind pmp_top pmp_props u_props (.CLK, .RSTN, .FETCH_EN, .FETCH_VALID, .FETCH_ADDR, .INT_ENTRY,
  .EXEC_VIOL_RST, .IND_RD, .POINTER_HIGH_BYTE, .IND_BUSY, .IND_VALID, .NV_RD, .NV_WR, .NV_ADDR,
  .NV_VALID, .EE_WR, .WRITE_ERROR);
